// >>> pkg/otgc_pkg.sv
// package for the on-the-go supply and line control register
// Overview of operation
// RQ1: reads answer at 0Ah to 0Ch; write 0Ah, set 0Bh, clear 0Ch.
// RQ2: set access sets ones in data; clear access clears them; others hold.
// RQ3: bit 7 low selects internal comparator, high selects fault pin as supply valid.
// RQ4: bit 6 high selects external supply and pulls power switch low.
// RQ5: bit 5 drives the bus supply; link may leave it clear with bit 6 set.
// RQ6: bit 4 charges the supply; link sets it only after discharge and 2 ms low.
// RQ7: bit 3 discharges the supply; link clears it after session end rises.
// RQ8: bit 2, reset high, connects the minus line pull-down.
// RQ9: bit 1, reset high, connects the plus line pull-down.
// RQ10: bit 0 enables identification pull-up and sampler; low saves power.
package otgc_pkg;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [5:0] OTGC_ADDR_WRITE = 6'h0a;
    localparam logic [5:0] OTGC_ADDR_SET = 6'h0b;
    localparam logic [5:0] OTGC_ADDR_CLEAR = 6'h0c;

    // ----------------------------------------------------------------
    // field positions and reset value
    // ----------------------------------------------------------------
    localparam int OTGC_BIT_FAULT_SEL = 7;
    localparam int OTGC_BIT_EXT_SUPPLY = 6;
    localparam int OTGC_BIT_DRIVE = 5;
    localparam int OTGC_BIT_CHARGE = 4;
    localparam int OTGC_BIT_DISCHARGE = 3;
    localparam int OTGC_BIT_MINUS_PD = 2;
    localparam int OTGC_BIT_PLUS_PD = 1;
    localparam int OTGC_BIT_IDENT = 0;
    localparam logic [7:0] OTGC_RESET_VALUE = 8'h06;
    localparam int OTGC_SYNC_STAGES = 2;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic externalFaultSelect;
        logic externalSupplySelect;
        logic supplyDrive;
        logic busSupplyCharge;
        logic busSupplyDischarge;
        logic minusLinePulldown;
        logic plusLinePulldown;
        logic cableIdentSampler;
    } otgc_ctrl_t;

    typedef struct packed {
        logic [5:0] addr;
        logic write;
        logic read;
        logic [7:0] wdata;
    } otgc_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } otgc_rsp_t;

    typedef struct packed {
        logic fault;
        logic comparator;
        logic ident;
    } otgc_pins_t;

    typedef struct packed {
        logic pumpEnable;
        logic supplyDrive;
        logic busSupplyCharge;
        logic busSupplyDischarge;
        logic minusLinePulldown;
        logic plusLinePulldown;
        logic cableIdentSampler;
    } otgc_analog_t;

endpackage : otgc_pkg

// >>> logic/otgc_sync.sv
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module otgc_sync
    import otgc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire otgc_pins_t pinsAsync,
    output otgc_pins_t pinsSync
);

    otgc_pins_t stageOne_reg;

    // first stage feeds only the second
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            stageOne_reg <= '0;
            pinsSync <= '0;
        end
        else if (clkEn)
        begin
            stageOne_reg <= pinsAsync;
            pinsSync <= stageOne_reg;
        end
    end

endmodule : otgc_sync

// >>> logic/otgc_control.sv
// on-the-go supply and line control register with its output steering
`timescale 1ns/1ps
module otgc_control
    import otgc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire otgc_req_t regReq,
    output otgc_rsp_t regRsp,
    input wire otgc_pins_t pinsAsync,
    output otgc_analog_t analogCtrl,
    output logic supplyValid,
    output logic identLevel,
    output logic powerSwitchNOut,
    output logic powerSwitchNOeN
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    otgc_ctrl_t ctrl_reg;
    otgc_ctrl_t ctrl_next;
    otgc_pins_t pinsSync;
    logic addrHit;

    assign addrHit = (regReq.addr == OTGC_ADDR_WRITE) || (regReq.addr == OTGC_ADDR_SET)
        || (regReq.addr == OTGC_ADDR_CLEAR); // [RQ1]

    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (regReq.write)
        begin
            case (regReq.addr)
                OTGC_ADDR_WRITE: ctrl_next = otgc_ctrl_t'(regReq.wdata); // [RQ1]
                OTGC_ADDR_SET: ctrl_next = otgc_ctrl_t'(ctrl_reg | regReq.wdata); // [RQ2]
                OTGC_ADDR_CLEAR: ctrl_next = otgc_ctrl_t'(ctrl_reg & ~regReq.wdata); // [RQ2]
                default: ctrl_next = ctrl_reg;
            endcase
        end
    end

    // pull-downs come up connected, everything else off
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ctrl_reg <= otgc_ctrl_t'(OTGC_RESET_VALUE); // [RQ8] [RQ9]
        else if (clkEn)
            ctrl_reg <= ctrl_next;
    end

    // ----------------------------------------------------------------
    // read answer
    // ----------------------------------------------------------------
    // answer shows contents before a same-cycle write
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            regRsp <= '0;
        else if (clkEn)
        begin
            regRsp.valid <= regReq.read && !regReq.write && addrHit; // [RQ1]
            regRsp.data <= (regReq.read && addrHit) ? 8'(ctrl_reg) : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    otgc_sync u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .pinsAsync(pinsAsync),
        .pinsSync(pinsSync)
    );

    // ----------------------------------------------------------------
    // supply valid source
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            supplyValid <= 1'b0;
        else if (clkEn)
            supplyValid <= ctrl_reg.externalFaultSelect ? pinsSync.fault
                : pinsSync.comparator; // [RQ3]
    end

    // ----------------------------------------------------------------
    // identification sampler
    // ----------------------------------------------------------------
    // reads zero while the sampler is powered down
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            identLevel <= 1'b0;
        else if (clkEn)
            identLevel <= ctrl_reg.cableIdentSampler && pinsSync.ident; // [RQ10]
    end

    // ----------------------------------------------------------------
    // analog steering
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            analogCtrl <= '0;
            analogCtrl.minusLinePulldown <= 1'b1;
            analogCtrl.plusLinePulldown <= 1'b1;
        end
        else if (clkEn)
        begin
            // internal pump only when the external path is not selected
            analogCtrl.pumpEnable <= ctrl_reg.supplyDrive
                && !ctrl_reg.externalSupplySelect; // [RQ4] [RQ5]
            analogCtrl.supplyDrive <= ctrl_reg.supplyDrive; // [RQ5]
            analogCtrl.busSupplyCharge <= ctrl_reg.busSupplyCharge; // [RQ6]
            analogCtrl.busSupplyDischarge <= ctrl_reg.busSupplyDischarge; // [RQ7]
            analogCtrl.minusLinePulldown <= ctrl_reg.minusLinePulldown; // [RQ8]
            analogCtrl.plusLinePulldown <= ctrl_reg.plusLinePulldown; // [RQ9]
            analogCtrl.cableIdentSampler <= ctrl_reg.cableIdentSampler; // [RQ10]
        end
    end

    // ----------------------------------------------------------------
    // power switch open-drain pin
    // ----------------------------------------------------------------
    assign powerSwitchNOut = 1'b0;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            powerSwitchNOeN <= 1'b1;
        else if (clkEn)
            powerSwitchNOeN <= !ctrl_reg.externalSupplySelect; // [RQ4]
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    property p_write_plain;
        clkEn && regReq.write && regReq.addr == OTGC_ADDR_WRITE
            |=> 8'(ctrl_reg) == $past(regReq.wdata);
    endproperty
    a_write_plain: assert property (p_write_plain) // [RQ1]
        else $error("plain write not stored");

    property p_write_set;
        clkEn && regReq.write && regReq.addr == OTGC_ADDR_SET
            |=> 8'(ctrl_reg) == ($past(8'(ctrl_reg)) | $past(regReq.wdata));
    endproperty
    a_write_set: assert property (p_write_set) // [RQ2]
        else $error("set access wrong");

    property p_write_clear;
        clkEn && regReq.write && regReq.addr == OTGC_ADDR_CLEAR
            |=> 8'(ctrl_reg) == ($past(8'(ctrl_reg)) & ~$past(regReq.wdata));
    endproperty
    a_write_clear: assert property (p_write_clear) // [RQ2]
        else $error("clear access wrong");

    property p_read_answer;
        clkEn && regReq.read && !regReq.write && addrHit
            |=> regRsp.valid && regRsp.data == $past(8'(ctrl_reg));
    endproperty
    a_read_answer: assert property (p_read_answer) // [RQ1]
        else $error("read answer wrong");

    property p_fault_select;
        clkEn && ctrl_reg[OTGC_BIT_FAULT_SEL]
            |=> supplyValid == $past(pinsSync.fault);
    endproperty
    a_fault_select: assert property (p_fault_select) // [RQ3]
        else $error("supply valid not from fault pin");

    property p_comparator_select;
        clkEn && !ctrl_reg[OTGC_BIT_FAULT_SEL]
            |=> supplyValid == $past(pinsSync.comparator);
    endproperty
    a_comparator_select: assert property (p_comparator_select) // [RQ3]
        else $error("supply valid not from comparator");

    property p_switch_pin;
        clkEn ##1 clkEn |-> powerSwitchNOeN == !$past(ctrl_reg[OTGC_BIT_EXT_SUPPLY]);
    endproperty
    a_switch_pin: assert property (p_switch_pin) // [RQ4]
        else $error("power switch enable wrong");

    property p_pump;
        clkEn |=> analogCtrl.pumpEnable == ($past(ctrl_reg[OTGC_BIT_DRIVE])
            && !$past(ctrl_reg[OTGC_BIT_EXT_SUPPLY]));
    endproperty
    a_pump: assert property (p_pump) // [RQ5]
        else $error("pump enable wrong");

    property p_charge_discharge;
        clkEn |=> analogCtrl.busSupplyCharge == $past(ctrl_reg[OTGC_BIT_CHARGE])
            && analogCtrl.busSupplyDischarge == $past(ctrl_reg[OTGC_BIT_DISCHARGE]);
    endproperty
    a_charge_discharge: assert property (p_charge_discharge) // [RQ6] [RQ7]
        else $error("charge or discharge control wrong");

    property p_pulldowns;
        clkEn |=> analogCtrl.minusLinePulldown == $past(ctrl_reg[OTGC_BIT_MINUS_PD])
            && analogCtrl.plusLinePulldown == $past(ctrl_reg[OTGC_BIT_PLUS_PD]);
    endproperty
    a_pulldowns: assert property (p_pulldowns) // [RQ8] [RQ9]
        else $error("pull-down control wrong");

    property p_ident_off;
        clkEn && !ctrl_reg[OTGC_BIT_IDENT] |=> !identLevel && !analogCtrl.cableIdentSampler;
    endproperty
    a_ident_off: assert property (p_ident_off) // [RQ10]
        else $error("sampler active while disabled");

    c_set_access: cover property (clkEn && regReq.write && regReq.addr == OTGC_ADDR_SET);
    c_clear_access: cover property (clkEn && regReq.write && regReq.addr == OTGC_ADDR_CLEAR);
    c_external_supply: cover property (!powerSwitchNOeN);
    c_fault_used: cover property (ctrl_reg[OTGC_BIT_FAULT_SEL] && supplyValid);

endmodule : otgc_control

// >>> tb/otgc_link_model.sv
// link-side model that issues register accesses to the control block
`timescale 1ns/1ps
module otgc_link_model
    import otgc_pkg::*;
(
    input wire logic ref_clk,
    output otgc_req_t regReq,
    input wire otgc_rsp_t regRsp
);
    // ------------------------------------------------------------
    // one access, driven off the falling edge
    // ------------------------------------------------------------
    initial regReq = '0;

    task automatic access(input logic [5:0] addr, input logic wr, input logic [7:0] data,
        output otgc_rsp_t rsp);
        @(negedge ref_clk);
        regReq.addr = addr;
        regReq.write = wr;
        regReq.read = ~wr;
        regReq.wdata = data;
        @(negedge ref_clk);
        // read answer stands for one cycle only, take it now
        rsp = regRsp;
        regReq.write = 1'b0;
        regReq.read = 1'b0;
        // released data lines do not keep the last value
        regReq.wdata = ~data;
        // control outputs follow the register one cycle later
        @(negedge ref_clk);
    endtask : access
endmodule : otgc_link_model

// >>> tb/tb_otgc_control.sv
// self-checking bench for the supply and line control register
`timescale 1ns/1ps
module tb_otgc_control;
    import otgc_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clkEn = 1'b1;
    otgc_req_t regReq;
    otgc_rsp_t regRsp;
    otgc_pins_t pinsAsync = '0;
    otgc_analog_t analogCtrl;
    logic supplyValid;
    logic identLevel;
    logic powerSwitchNOut;
    logic powerSwitchNOeN;
    int errors = 0;
    int comparisons = 0;
    otgc_rsp_t rsp;

    // ------------------------------------------------------------
    // clock, design and link model
    // ------------------------------------------------------------
    always #10 ref_clk = ~ref_clk;

    otgc_control otgc_control_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .regReq(regReq), .regRsp(regRsp), .pinsAsync(pinsAsync), .analogCtrl(analogCtrl),
        .supplyValid(supplyValid), .identLevel(identLevel),
        .powerSwitchNOut(powerSwitchNOut), .powerSwitchNOeN(powerSwitchNOeN));

    otgc_link_model otgc_link_model_i (.ref_clk(ref_clk), .regReq(regReq), .regRsp(regRsp));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [5:0] addr, input logic [7:0] data);
        otgc_link_model_i.access(addr, 1'b1, data, rsp);
    endtask : wr

    task automatic rdchk(input logic [5:0] addr, input logic vld, input logic [7:0] exp);
        otgc_link_model_i.access(addr, 1'b0, 8'h00, rsp);
        chk({7'h00, rsp.valid}, {7'h00, vld});
        chk(rsp.data, exp);
    endtask : rdchk

    task automatic outchk(input logic [7:0] analogExp, input logic [7:0] switchExp);
        chk({1'b0, analogCtrl}, analogExp);
        chk({6'h00, powerSwitchNOut, powerSwitchNOeN}, switchExp);
    endtask : outchk

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset;
        outchk(8'h06, 8'h01);
        chk({6'h00, supplyValid, identLevel}, 8'h00);
        rdchk(OTGC_ADDR_WRITE, 1'b1, 8'h06);
        rdchk(OTGC_ADDR_SET, 1'b1, 8'h06);
        rdchk(OTGC_ADDR_CLEAR, 1'b1, 8'h06);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_access;
        wr(OTGC_ADDR_WRITE, 8'ha5);
        rdchk(OTGC_ADDR_WRITE, 1'b1, 8'ha5);
        wr(OTGC_ADDR_SET, 8'h50);
        rdchk(OTGC_ADDR_SET, 1'b1, 8'hf5);
        wr(OTGC_ADDR_CLEAR, 8'h81);
        rdchk(OTGC_ADDR_CLEAR, 1'b1, 8'h74);
        wr(6'h0d, 8'hff);
        rdchk(6'h0d, 1'b0, 8'h00);
        rdchk(OTGC_ADDR_WRITE, 1'b1, 8'h74);
        $display("test_access done");
    endtask : test_access

    task automatic test_outputs;
        wr(OTGC_ADDR_WRITE, 8'h20);
        outchk(8'h60, 8'h01);
        wr(OTGC_ADDR_SET, 8'h40);
        outchk(8'h20, 8'h00);
        wr(OTGC_ADDR_WRITE, 8'h0f);
        outchk(8'h0f, 8'h01);
        wr(OTGC_ADDR_CLEAR, 8'h08);
        outchk(8'h07, 8'h01);
        wr(OTGC_ADDR_SET, 8'h10);
        outchk(8'h17, 8'h01);
        wr(OTGC_ADDR_CLEAR, 8'h1f);
        outchk(8'h00, 8'h01);
        $display("test_outputs done");
    endtask : test_outputs

    task automatic test_select;
        @(negedge ref_clk);
        pinsAsync = '{fault: 1'b0, comparator: 1'b1, ident: 1'b1};
        wr(OTGC_ADDR_WRITE, 8'h00);
        repeat (4) @(negedge ref_clk);
        chk({6'h00, supplyValid, identLevel}, 8'h02);
        wr(OTGC_ADDR_WRITE, 8'h81);
        chk({6'h00, supplyValid, identLevel}, 8'h01);
        pinsAsync.fault = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk({6'h00, supplyValid, identLevel}, 8'h03);
        $display("test_select done");
    endtask : test_select

    // frozen clock enable ignores requests and holds all outputs
    task automatic test_freeze;
        @(negedge ref_clk);
        clkEn = 1'b0;
        pinsAsync.fault = 1'b0;
        wr(OTGC_ADDR_WRITE, 8'h3c);
        repeat (4) @(negedge ref_clk);
        outchk(8'h01, 8'h01);
        chk({6'h00, supplyValid, identLevel}, 8'h03);
        clkEn = 1'b1;
        rdchk(OTGC_ADDR_WRITE, 1'b1, 8'h81);
        repeat (4) @(negedge ref_clk);
        chk({6'h00, supplyValid, identLevel}, 8'h01);
        $display("test_freeze done");
    endtask : test_freeze

    // ------------------------------------------------------------
    // sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        test_reset();
        test_access();
        test_outputs();
        test_select();
        test_freeze();
        finish_test();
    end

    initial
    begin
        #100000;
        errors++;
        finish_test();
    end
endmodule : tb_otgc_control
